/* File: dsl_dac_load.sv */
`timescale 1ns/1ps
// Overview of operation
// - after select falls, data shifts in msb first on each rising serial clock
// - select rising after sixteen bits copies the shift register into the latch
// - serial clock edges are ignored while select is high
// - extra edges keep only the last sixteen bits for the latch
// - fourteen-bit variant: code left-justified, two trailing bits ignored
// - twelve-bit variant: code left-justified, four trailing bits ignored
// - zero-scale variant powers up with latch at code zero
// - midscale variant powers up with latch at its midscale code
// - clear low forces latch to its reset code without serial clock
// - top four latch bits decode to fifteen thermometer segments
module dsl_dac_load #(
  parameter int RESOLUTION = dsl_pkg::RES_16,
  parameter bit MIDSCALE = 1'b0
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic chip_sel_n,
  input wire logic ser_clk,
  input wire logic ser_din,
  input wire logic async_clear_n,
  output logic [RESOLUTION-1:0] dac_code,
  output logic [dsl_pkg::SEG_COUNT-1:0] seg_therm,
  output logic [RESOLUTION-dsl_pkg::SEG_BITS-1:0] bin_bits,
  output logic word_valid
);

  localparam int PAD = dsl_pkg::WORD_BITS - RESOLUTION;
  localparam int BIN_W = RESOLUTION - dsl_pkg::SEG_BITS;
  localparam logic [15:0] RESET_WORD = MIDSCALE ? dsl_pkg::MID_CODE : dsl_pkg::ZERO_CODE;

  // only the three documented word layouts have a slicing that makes sense
  if (RESOLUTION != dsl_pkg::RES_16 && RESOLUTION != dsl_pkg::RES_14 &&
      RESOLUTION != dsl_pkg::RES_12) begin : g_bad_resolution
    $error("unsupported resolution");
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] cs_sync_r;
  logic [1:0] sck_sync_r;
  logic [1:0] din_sync_r;
  logic [1:0] clr_sync_r;
  logic cs_last_r;
  logic sck_last_r;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cs_sync_r <= 2'h3;
      sck_sync_r <= 2'h0;
      din_sync_r <= 2'h0;
      clr_sync_r <= 2'h3;
      cs_last_r <= 1'b1;
      sck_last_r <= 1'b0;
    end else begin
      cs_sync_r <= {cs_sync_r[0], chip_sel_n};
      sck_sync_r <= {sck_sync_r[0], ser_clk};
      din_sync_r <= {din_sync_r[0], ser_din};
      clr_sync_r <= {clr_sync_r[0], async_clear_n};
      cs_last_r <= cs_sync_r[1];
      sck_last_r <= sck_sync_r[1];
    end
  end

  logic cs_low;
  logic cs_rise;
  logic sck_rise;
  logic clear_act;
  assign cs_low = ~cs_sync_r[1];
  assign cs_rise = cs_sync_r[1] & ~cs_last_r;
  assign sck_rise = sck_sync_r[1] & ~sck_last_r;
  // the clear acts on the sampled level; at 250 MHz a 10 ns pulse spans
  // CLEAR_MIN_CYC samples, so it is always seen, at the cost of a 2-cycle lag
  assign clear_act = ~clr_sync_r[1];

  // ****************************************
  // shift register and bit count
  // ****************************************
  logic [15:0] shift_r;
  logic [4:0] count_r;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      shift_r <= 16'h0000;
      count_r <= 5'h00;
    end else if (!cs_low) begin
      if (cs_rise) begin
        count_r <= 5'h00;
      end
    end else if (sck_rise) begin
      // oldest bit falls off the top
      shift_r <= {shift_r[14:0], din_sync_r[1]};
      if (count_r != dsl_pkg::WORD_COUNT_FULL) begin
        count_r <= count_r + 5'h01;
      end
    end
  end

  // ****************************************
  // dac latch
  // ****************************************
  logic [RESOLUTION-1:0] latch_r;
  logic [RESOLUTION-1:0] latch_nxt;

  always_comb begin
    latch_nxt = latch_r;
    if (clear_act) begin
      latch_nxt = RESET_WORD[15 -: RESOLUTION];
    end else if (cs_rise && count_r == dsl_pkg::WORD_COUNT_FULL) begin
      latch_nxt = shift_r[15 -: RESOLUTION];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      latch_r <= RESET_WORD[15 -: RESOLUTION];
      word_valid <= 1'b0;
    end else begin
      latch_r <= latch_nxt;
      word_valid <= cs_rise && !clear_act && count_r == dsl_pkg::WORD_COUNT_FULL;
    end
  end

  // ****************************************
  // segment decode
  // ****************************************
  logic [dsl_pkg::SEG_COUNT-1:0] therm_nxt;
  genvar gi;
  generate
    for (gi = 0; gi < dsl_pkg::SEG_COUNT; gi++) begin : g_seg
      assign therm_nxt[gi] = latch_nxt[RESOLUTION-1 -: dsl_pkg::SEG_BITS] > gi;
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dac_code <= RESET_WORD[15 -: RESOLUTION];
      seg_therm <= MIDSCALE ? 15'h00ff : 15'h0000;
      bin_bits <= '0;
    end else begin
      dac_code <= latch_nxt;
      seg_therm <= therm_nxt;
      bin_bits <= latch_nxt[BIN_W-1:0];
    end
  end

endmodule : dsl_dac_load

/* File: dsl_pkg.sv */
package dsl_pkg;

  // ****************************************
  // word format
  // ****************************************
  localparam int WORD_BITS = 16;
  localparam int SEG_BITS = 4;
  localparam int SEG_COUNT = 15;
  localparam logic [4:0] WORD_COUNT_FULL = 5'h10;

  // ****************************************
  // variants
  // ****************************************
  localparam int RES_16 = 16;
  localparam int RES_14 = 14;
  localparam int RES_12 = 12;
  localparam logic [15:0] ZERO_CODE = 16'h0000;
  // midscale is the top code bit set, left-justified, so it is 8000 for all widths
  localparam logic [15:0] MID_CODE = 16'h8000;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 4000;
  localparam int CLEAR_MIN_NS = 10;
  // shortest clear low pulse, rounded up to whole cycles
  localparam int CLEAR_MIN_CYC =
    (CLEAR_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage : dsl_pkg

/* File: dsl_dac_load_properties.sv */
`timescale 1ns/1ps
module dsl_dac_load_properties #(
  parameter int RESOLUTION = 16,
  parameter bit MIDSCALE = 1'b0
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic chip_sel_n,
  input wire logic async_clear_n,
  input wire logic [RESOLUTION-1:0] dac_code,
  input wire logic [14:0] seg_therm,
  input wire logic [RESOLUTION-5:0] bin_bits,
  input wire logic word_valid
);
  localparam logic [RESOLUTION-1:0] RST_CODE = {MIDSCALE, {(RESOLUTION-1){1'b0}}};
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_clear_held;
    !async_clear_n [*3];
  endsequence
  AST_THERM:
  assert property (seg_therm == 15'((16'h1 << dac_code[RESOLUTION-1 -: 4]) - 16'h1))
    else $error("thermometer mismatch");
  AST_BIN:
  assert property (bin_bits == dac_code[RESOLUTION-5:0]) else $error("binary bits mismatch");
  AST_HOLD:
  assert property ($changed(dac_code) |-> word_valid || !($past(async_clear_n, 2)
    && $past(async_clear_n, 3) && $past(async_clear_n, 4))) else $error("latch moved");
  AST_LOAD_AFTER_RISE:
  assert property (word_valid |-> chip_sel_n && $past(chip_sel_n, 3)) else $error("early load");
  AST_NO_LOAD_IN_FRAME:
  assert property (!chip_sel_n [*4] |-> !word_valid) else $error("load inside frame");
  AST_PULSE:
  assert property (word_valid |=> !word_valid) else $error("valid too long");
  AST_CLEAR:
  assert property (s_clear_held |=> dac_code == RST_CODE) else $error("clear missed");
  AST_RESET:
  assert property (disable iff (1'b0) sys_rst |=> dac_code == RST_CODE && !word_valid)
    else $error("reset code wrong");
endmodule : dsl_dac_load_properties

/* File: dsl_host_model.sv */
`timescale 1ns/1ps
module dsl_host_model (
  output logic chip_sel_n,
  output logic ser_clk,
  output logic ser_din
);
  initial begin
    chip_sel_n = 1'b1;
    ser_clk = 1'b0;
    ser_din = 1'b0;
  end
  task automatic send(input logic [23:0] w, input int n);
    chip_sel_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      #31 ser_din = w[i];
      #31 ser_clk = 1'b1;
      #63 ser_clk = 1'b0;
    end
    #31 chip_sel_n = 1'b1;
    ser_din = ~ser_din;
  endtask : send
endmodule : dsl_host_model

/* File: dsl_dac_load_tb.sv */
`timescale 1ns/1ps
module dsl_dac_load_tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic async_clear_n = 1'b1;
  logic chip_sel_n, ser_clk, ser_din, word_valid;
  logic [15:0] dac_code;
  logic [14:0] seg_therm;
  logic [11:0] bin_bits;
  logic [11:0] dac_code12;
  logic [14:0] seg_therm12;
  logic [7:0] bin_bits12;
  logic word_valid12;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  int loads = 0;
  always #2 core_clk = ~core_clk;
  dsl_dac_load #(.RESOLUTION(16), .MIDSCALE(1'b1)) uut (.core_clk, .sys_rst, .chip_sel_n,
    .ser_clk, .ser_din, .async_clear_n, .dac_code, .seg_therm, .bin_bits, .word_valid);
  dsl_host_model host (.chip_sel_n, .ser_clk, .ser_din);
  // second variant: 12-bit zero-scale, fed by the same host frames
  dsl_dac_load #(.RESOLUTION(12), .MIDSCALE(1'b0)) uut_12 (.core_clk, .sys_rst, .chip_sel_n,
    .ser_clk, .ser_din, .async_clear_n, .dac_code(dac_code12), .seg_therm(seg_therm12),
    .bin_bits(bin_bits12), .word_valid(word_valid12));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    if (errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  always @(posedge core_clk) begin
    cycles++;
    if (word_valid === 1'b1) loads++;
    if (word_valid12 === 1'b1) loads++;
    if (cycles == 5000) begin
      errors++;
      summarize();
    end
  end
  task automatic expect_code(input logic [15:0] c, input logic [11:0] c12);
    repeat (8) @(negedge core_clk);
    chk(dac_code, c);
    chk({1'b0, seg_therm}, 16'((17'h1 << c[15:12]) - 17'h1));
    chk({4'h0, bin_bits}, {4'h0, c[11:0]});
    chk({4'h0, dac_code12}, {4'h0, c12});
    chk({1'b0, seg_therm12}, 16'((17'h1 << c12[11:8]) - 17'h1));
    chk({8'h00, bin_bits12}, {8'h00, c12[7:0]});
  endtask : expect_code
  task automatic t_load();
    int n;
    n = loads;
    host.send(24'h00a5c3, 16);
    expect_code(16'ha5c3, 12'ha5c);
    chk(16'(loads - n), 16'h0002);
  endtask : t_load
  task automatic t_long();
    int n;
    n = loads;
    host.send(24'h0f1234, 20);
    expect_code(16'h1234, 12'h123);
    chk(16'(loads - n), 16'h0002);
  endtask : t_long
  task automatic t_short();
    int n;
    n = loads;
    host.send(24'h000077, 10);
    expect_code(16'h1234, 12'h123);
    chk(16'(loads - n), 16'h0000);
  endtask : t_short
  task automatic t_clear();
    async_clear_n = 1'b0;
    repeat (5) @(negedge core_clk);
    async_clear_n = 1'b1;
    expect_code(16'h8000, 12'h000);
  endtask : t_clear
  initial begin
    repeat (4) @(negedge core_clk);
    sys_rst = 1'b0;
    expect_code(16'h8000, 12'h000);
    t_load();
    t_long();
    t_short();
    t_clear();
    summarize();
  end
endmodule : dsl_dac_load_tb
bind dsl_dac_load dsl_dac_load_properties #(.RESOLUTION(RESOLUTION), .MIDSCALE(MIDSCALE))
  u_props (.core_clk, .sys_rst, .chip_sel_n, .async_clear_n, .dac_code, .seg_therm,
  .bin_bits, .word_valid);
